// ===== load_adaptive_fullstep_commutation.sv
// Load-adaptive full-step commutation for one motor axis
`timescale 1ns/10ps
`include "load_adaptive_consts.svh"
module load_adaptive_fullstep_commutation
  import load_adaptive_pkg::*;
(
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     reset_n,
  // Ramp generator side
  input  wire logic                     internalRamp,
  input  wire logic [`VEL_W-1:0]        rampTargetVelocity,
  input  wire logic [`VEL_W-1:0]        ramp_max_velocity,
  output logic [`VEL_W-1:0]             actual_velocity,
  output logic                          motionFeedback,
  output logic                          rampHold,
  // Configuration
  input  wire logic [`VEL_W-1:0]        adaptive_min_velocity,
  input  wire logic                     silentChopperEnable,
  input  wire logic                     highVelFullstep,
  input  wire logic                     highVelChopper,
  input  wire logic [`TOFF_W-1:0]       offTimeSetting,
  input  wire logic [`PW_W-1:0]         load_ref_pulse_width,
  input  wire logic [`SENS_W-1:0]       adaptive_stall_sensitivity,
  input  wire logic                     stop_on_stall_enable,
  input  wire logic [`VEL_W-1:0]        load_measure_velocity_threshold,
  // Status
  input  wire logic                     stall_stop_event_clear,
  output logic                          stall_stop_event_flag,
  output logic                          stallFlag,
  output logic [`LOAD_W-1:0]            loadValue,
  output logic                          adaptiveActive,
  // Bridge side
  input  wire logic                     coilFeedbackPin,
  input  wire logic                     standardStall,
  output logic [`MICROSTEP_POSITION_COUNTER_W-1:0]           microstep_position_counter,
  output logic                          fullStepMode,
  output logic                          constOffChopper,
  output logic [`TOFF_W-1:0]            effOffTime
);

  // ************************************************************
  // Input synchroniser
  // ************************************************************
  logic fbMeta_r;
  logic fbSync_r;
  logic fbPrev_r;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fbMeta_r <= 1'b0;
      fbSync_r <= 1'b0;
      fbPrev_r <= 1'b0;
    end else begin
      fbMeta_r <= coilFeedbackPin;
      fbSync_r <= fbMeta_r;
      fbPrev_r <= fbSync_r;
    end
  end
  // Rising feedback edge marks the motor completing one full step
  wire fbEdge = fbSync_r & ~fbPrev_r;

  // ************************************************************
  // Mode selection
  // ************************************************************
  cmode_t mode_r;
  cmode_t mode_nxt;
  wire modeAllowed = internalRamp
                   & (adaptive_min_velocity != '0)
                   & ~silentChopperEnable
                   & highVelFullstep & highVelChopper;
  wire aboveMin = rampTargetVelocity > adaptive_min_velocity;
  // Offsets 8..15 behave the same, low values clamp up
  wire [`TOFF_W-1:0] toffClamp =
    (offTimeSetting > `TOFF_CAP) ? `TOFF_CAP :
    (offTimeSetting < `TOFF_MIN) ? `TOFF_MIN : offTimeSetting;

  // ************************************************************
  // Load measurement against reference pulse
  // ************************************************************
  logic [`PW_W:0]   pulseCnt_r;
  logic [`LOAD_W-1:0] load_r;
  logic             blocked_r;
  wire [`PW_W:0] refWidth = {1'b0, load_ref_pulse_width};
  // Higher sensitivity leaves less headroom before a slow pulse is a stall
  wire [`PW_W+1:0] stallReach = {1'b0, pulseCnt_r} +
    ({4'h0, adaptive_stall_sensitivity} << `SENS_SHIFT);
  // Load: 0..255 while pulse within reference, up to 511 when slipping
  wire [`PW_W:0] overRef = (pulseCnt_r > refWidth) ? pulseCnt_r - refWidth : '0;
  // Wide enough for the scaled pulse; a pulse equal to the reference reads 255
  wire [`PW_W+7:0] pulseScaled = {pulseCnt_r[`PW_W-1:0], 8'h00};
  wire [`PW_W+7:0] refDiv = (refWidth == '0) ? 18'h00001 : {7'h00, refWidth};
  wire [`PW_W+7:0] pulseRatio = pulseScaled / refDiv;
  wire [`LOAD_W-1:0] loadCalc =
    (pulseCnt_r < refWidth) ? pulseRatio[`LOAD_W-1:0] :
      ((overRef > 11'h0FF) ? `LOAD_SLIP_MAX :
        `LOAD_W'(`LOAD_NORMAL_MAX + {1'b0, overRef[7:0]}));
  wire pulseOverrun = (stallReach > `STALL_SPAN) &
                      (adaptive_stall_sensitivity != '0);
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pulseCnt_r <= '0;
      load_r     <= '0;
      blocked_r  <= 1'b0;
    end else if (mode_r != MODE_ADAPTIVE || fbEdge) begin
      pulseCnt_r <= '0;
      if (fbEdge)
        load_r <= loadCalc;
      blocked_r  <= 1'b0;
    end else begin
      if (pulseCnt_r != '1)
        pulseCnt_r <= pulseCnt_r + 1'b1;
      blocked_r  <= pulseOverrun;
    end
  end
  assign loadValue = load_r;

  // ************************************************************
  // Step rate generation
  // ************************************************************
  logic [`PHASE_ACC_W-1:0] phase_r;
  logic [`PHASE_ACC_W-1:0] minPhase_r;
  logic                    stepPend_r;
  logic                    awaitFb_r;
  // Runs at target or max velocity, never below the floor
  wire [`VEL_W-1:0] capVel = (rampTargetVelocity > ramp_max_velocity) ?
                             ramp_max_velocity : rampTargetVelocity;
  wire [`VEL_W-1:0] stepVel = (capVel < adaptive_min_velocity) ?
                              adaptive_min_velocity : capVel;
  wire [`PHASE_ACC_W:0] phaseSum = {1'b0, phase_r} + {5'b00000, stepVel};
  wire rateTick = phaseSum[`PHASE_ACC_W];
  // Floor clock restarts at each step, so a blocked motor still steps at minimum
  wire [`PHASE_ACC_W:0] minSum = {1'b0, minPhase_r} + {5'b00000, adaptive_min_velocity};
  wire minTick = minSum[`PHASE_ACC_W];
  wire stepReq = stepPend_r | rateTick;
  // Overload slows stepping: a step waits for the motor's own edge
  wire stepNow = (mode_r == MODE_ADAPTIVE) &
                 ((stepReq & (~awaitFb_r | fbEdge)) | minTick);
  wire [`VEL_W-1:0] microVel = rampTargetVelocity;
  wire [`PHASE_ACC_W:0] microSum = {1'b0, phase_r} + {5'b00000, microVel};
  wire microTick = (mode_r == MODE_MICROSTEP) & microSum[`PHASE_ACC_W];

  // ************************************************************
  // Mode state machine
  // ************************************************************
  wire stallEvent = ((mode_r == MODE_ADAPTIVE) & blocked_r) |
                    ((mode_r == MODE_MICROSTEP) & standardStall);
  wire stopHold = stop_on_stall_enable & stall_stop_event_flag;
  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      MODE_MICROSTEP:
        if (stopHold)
          mode_nxt = MODE_STALLED;
        else if (modeAllowed && aboveMin)
          mode_nxt = MODE_ADAPTIVE;
      MODE_ADAPTIVE:
        if (stop_on_stall_enable && blocked_r)
          mode_nxt = MODE_STALLED;
        else if (!modeAllowed || !aboveMin)
          mode_nxt = MODE_MICROSTEP;
      MODE_STALLED:
        if (!stopHold)
          mode_nxt = MODE_MICROSTEP;
    endcase
  end

  // ************************************************************
  // Position, flags and registered outputs
  // ************************************************************
  logic [`MICROSTEP_POSITION_COUNTER_W-1:0] microstep_position_counter_r;
  logic                evFlag_r;
  logic                stall_r;
  logic [`VEL_W-1:0]   vact_r;
  logic                fb_r;
  logic [`TOFF_W-1:0]  offTime_r;
  wire stallSet = stop_on_stall_enable & stallEvent;
  // Snap to the next full-step point so the quadrant polarity stays clean
  wire [`MICROSTEP_POSITION_COUNTER_W-1:0] fullNext = {microstep_position_counter_r[`MICROSTEP_POSITION_COUNTER_W-1:8], 8'h80} + `FULLSTEP_INC;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_r     <= MODE_MICROSTEP;
      microstep_position_counter_r    <= '0;
      phase_r    <= '0;
      minPhase_r <= '0;
      stepPend_r <= 1'b0;
      awaitFb_r  <= 1'b0;
      offTime_r  <= `TOFF_MIN;
      evFlag_r   <= 1'b0;
      stall_r    <= 1'b0;
      vact_r     <= '0;
      fb_r       <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      offTime_r <= toffClamp;
      if (mode_r == MODE_ADAPTIVE) begin
        phase_r    <= phaseSum[`PHASE_ACC_W-1:0];
        minPhase_r <= stepNow ? '0 : minSum[`PHASE_ACC_W-1:0];
        stepPend_r <= stepReq & ~stepNow;
        // A new step waits for its own edge, so it beats a late old edge
        awaitFb_r  <= stepNow | (awaitFb_r & ~fbEdge);
      end else begin
        phase_r    <= microSum[`PHASE_ACC_W-1:0];
        minPhase_r <= '0;
        stepPend_r <= 1'b0;
        awaitFb_r  <= 1'b0;
      end
      if (stepNow)
        microstep_position_counter_r <= fullNext;
      else if (microTick)
        microstep_position_counter_r <= microstep_position_counter_r + 1'b1;
      // Set wins over a clear in the same cycle
      if (stallSet)
        evFlag_r <= 1'b1;
      else if (stall_stop_event_clear || !stop_on_stall_enable)
        evFlag_r <= 1'b0;
      if (stallEvent)
        stall_r <= 1'b1;
      else if (mode_r == MODE_MICROSTEP && !standardStall)
        stall_r <= 1'b0;
      vact_r <= (mode_nxt == MODE_STALLED) ? '0 : rampTargetVelocity;
      fb_r   <= stepNow;
    end
  end

  assign microstep_position_counter = microstep_position_counter_r;
  assign stall_stop_event_flag      = evFlag_r;
  assign stallFlag                  = stall_r;
  assign actual_velocity            = vact_r;
  assign motionFeedback             = fb_r;
  // Ramp waits while the motor lags; rate drops to what the motor achieves
  assign rampHold        = (mode_r == MODE_ADAPTIVE) & stepPend_r & awaitFb_r;
  assign adaptiveActive  = (mode_r == MODE_ADAPTIVE);
  assign fullStepMode    = (mode_r == MODE_ADAPTIVE);
  assign constOffChopper = (mode_r == MODE_ADAPTIVE);
  assign effOffTime      = offTime_r;

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_stopZero;
    @(posedge core_clk) disable iff (!reset_n)
      (mode_r == MODE_STALLED) |-> (actual_velocity == '0);
  endproperty
  a_stopZero: assert property (p_stopZero) else $error("velocity not zero in stall stop");

  property p_noExtStep;
    @(posedge core_clk) disable iff (!reset_n)
      !internalRamp |=> (mode_r != MODE_ADAPTIVE);
  endproperty
  a_noExtStep: assert property (p_noExtStep) else $error("adaptive mode without ramp");

  property p_zeroMinOff;
    @(posedge core_clk) disable iff (!reset_n)
      (adaptive_min_velocity == '0) |=> !adaptiveActive;
  endproperty
  a_zeroMinOff: assert property (p_zeroMinOff) else $error("adaptive with zero minimum");

  property p_silentOff;
    @(posedge core_clk) disable iff (!reset_n)
      silentChopperEnable |=> !adaptiveActive;
  endproperty
  a_silentOff: assert property (p_silentOff) else $error("adaptive with silent chopper");

  property p_flagSet;
    @(posedge core_clk) disable iff (!reset_n)
      stallSet |=> stall_stop_event_flag;
  endproperty
  a_flagSet: assert property (p_flagSet) else $error("stall stop flag not set");

  property p_toffCap;
    @(posedge core_clk) disable iff (!reset_n)
      (offTimeSetting >= `TOFF_CAP) |=> (effOffTime == `TOFF_CAP);
  endproperty
  a_toffCap: assert property (p_toffCap) else $error("off-time not capped at 8");

  property p_vactTarget;
    @(posedge core_clk) disable iff (!reset_n)
      (mode_nxt != MODE_STALLED) |=> (actual_velocity == $past(rampTargetVelocity));
  endproperty
  a_vactTarget: assert property (p_vactTarget) else $error("velocity not ramp target");

  property p_loadRange;
    @(posedge core_clk) disable iff (!reset_n)
      $changed(loadValue) && (mode_r == MODE_ADAPTIVE) && $past(pulseCnt_r) <= $past(refWidth)
        |-> loadValue <= `LOAD_NORMAL_MAX;
  endproperty
  a_loadRange: assert property (p_loadRange) else $error("load out of normal range");

  sequence s_stopped;
    stop_on_stall_enable && stall_stop_event_flag && !stall_stop_event_clear;
  endsequence
  property p_stayStopped;
    @(posedge core_clk) disable iff (!reset_n)
      (mode_r == MODE_STALLED) ##0 s_stopped |=> (mode_r == MODE_STALLED);
  endproperty
  a_stayStopped: assert property (p_stayStopped) else $error("left stall stop early");

endmodule

// ===== load_adaptive_consts.svh
// Constants for the load-adaptive full-step commutation block
`ifndef LOAD_ADAPTIVE_CONSTS_SVH
`define LOAD_ADAPTIVE_CONSTS_SVH
`define VEL_W            20
`define TOFF_W           4
`define TOFF_MIN         4'h2
`define TOFF_CAP         4'h8
`define PW_W             10
`define SENS_W           8
`define LOAD_W           9
`define LOAD_NORMAL_MAX  9'h0FF
`define LOAD_SLIP_MAX    9'h1FF
`define MICROSTEP_POSITION_COUNTER_W          10
`define MICROSTEP_POSITION_COUNTER_QUARTER    10'h100
`define MICROSTEP_POSITION_COUNTER_HALF       10'h200
`define MICROSTEP_POSITION_COUNTER_THREEQ     10'h300
`define FULLSTEP_INC     10'h100
`define OFFTIME_UNIT     8'h20
`define SENS_SHIFT       4
`define PHASE_ACC_W      24
`define STALL_SPAN       12'h7FF
`endif

// ===== load_adaptive_pkg.sv
// Types for the load-adaptive full-step commutation block
package load_adaptive_pkg;
  typedef enum logic [1:0] {
    MODE_MICROSTEP,
    MODE_ADAPTIVE,
    MODE_STALLED
  } cmode_t;
endpackage

// ===== motor_coil_model.sv
// Two-coil motor model answering each commutation step with a feedback edge unless blocked
`timescale 1ns/10ps
`include "load_adaptive_consts.svh"
module motor_coil_model #(
  parameter int LAG = 5
) (
  // Clock
  input  wire logic                core_clk,
  // Bridge side
  input  wire logic [`MICROSTEP_POSITION_COUNTER_W-1:0] microstep_position_counter,
  input  wire logic                blocked,
  output logic                     coilFeedbackPin
);
  // ****
  // Step response
  // ****
  logic [1:0]          lastPol = 2'b11;
  logic [15:0]         lagPipe = '0;
  // Coil polarity by wave quadrant: sine positive 768..255, cosine 0..511
  wire  [1:0]          coilPol = {~(microstep_position_counter[`MICROSTEP_POSITION_COUNTER_W-1] ^
                                    microstep_position_counter[`MICROSTEP_POSITION_COUNTER_W-2]),
                                  ~microstep_position_counter[`MICROSTEP_POSITION_COUNTER_W-1]};
  initial coilFeedbackPin = 1'b0;
  // Two-cycle high so the pin survives the two-flop synchroniser
  always @(posedge core_clk) begin
    lagPipe <= {lagPipe[14:0], (coilPol != lastPol) && !blocked};
    lastPol <= coilPol;
    coilFeedbackPin <= lagPipe[LAG] | lagPipe[LAG+1];
  end
endmodule

// ===== tb_top.sv
// Self-checking bench for the load-adaptive full-step commutation block
`timescale 1ns/10ps
`include "load_adaptive_consts.svh"
module tb_top;
  import load_adaptive_pkg::*;
  // ****
  // Stimulus and observed signals
  // ****
  logic core_clk = 1'b0, reset_n = 1'b0, internalRamp = 1'b0, silentChopperEnable = 1'b0;
  logic highVelFullstep = 1'b0, highVelChopper = 1'b0, stop_on_stall_enable = 1'b0;
  logic stall_stop_event_clear = 1'b0, standardStall = 1'b0, blocked = 1'b0;
  logic [`VEL_W-1:0] rampTargetVelocity = '0, ramp_max_velocity = '0;
  logic [`VEL_W-1:0] adaptive_min_velocity = '0, load_measure_velocity_threshold = '0;
  logic [`TOFF_W-1:0] offTimeSetting = '0, effOffTime;
  logic [`PW_W-1:0] load_ref_pulse_width = '0;
  logic [`SENS_W-1:0] adaptive_stall_sensitivity = '0;
  logic [`VEL_W-1:0] actual_velocity;
  logic [`LOAD_W-1:0] loadValue;
  logic [`MICROSTEP_POSITION_COUNTER_W-1:0] microstep_position_counter;
  logic motionFeedback, rampHold, stall_stop_event_flag, stallFlag, adaptiveActive;
  logic fullStepMode, constOffChopper, coilFeedbackPin;
  int errCount = 0, nCompared = 0, fbCount = 0, k;
  logic [15:0] lfsr = 16'h0046;
  logic [`VEL_W-1:0] v;
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) if (motionFeedback === 1'b1) fbCount++;
  load_adaptive_fullstep_commutation load_adaptive_fullstep_commutation_i (.core_clk, .reset_n,
    .internalRamp, .rampTargetVelocity, .ramp_max_velocity, .actual_velocity, .motionFeedback,
    .rampHold, .adaptive_min_velocity, .silentChopperEnable, .highVelFullstep, .highVelChopper,
    .offTimeSetting, .load_ref_pulse_width, .adaptive_stall_sensitivity, .stop_on_stall_enable,
    .load_measure_velocity_threshold, .stall_stop_event_clear, .stall_stop_event_flag,
    .stallFlag, .loadValue, .adaptiveActive, .coilFeedbackPin, .standardStall,
    .microstep_position_counter, .fullStepMode, .constOffChopper, .effOffTime);
  motor_coil_model motor_coil_model_i (.core_clk, .microstep_position_counter, .blocked,
    .coilFeedbackPin);
  // ****
  // Helpers
  // ****
  function automatic logic [15:0] nextRand(input logic [15:0] s);
    return s[0] ? ((s >> 1) ^ 16'hB400) : (s >> 1);
  endfunction
  function automatic logic [`TOFF_W-1:0] clampOff(input logic [`TOFF_W-1:0] x);
    return (x < `TOFF_MIN) ? `TOFF_MIN : ((x > `TOFF_CAP) ? `TOFF_CAP : x);
  endfunction
  task automatic chk(input string name, input logic [19:0] exp, input logic [19:0] got);
    nCompared++;
    if (got !== exp) begin
      errCount++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic setGood();
    @(posedge core_clk);
    internalRamp <= 1'b1;
    adaptive_min_velocity <= 20'h10000;
    load_measure_velocity_threshold <= 20'h10001;
    silentChopperEnable <= 1'b0;
    highVelFullstep <= 1'b1;
    highVelChopper <= 1'b1;
    rampTargetVelocity <= 20'hFFFFF;
    ramp_max_velocity <= 20'hFFFFF;
    adaptive_stall_sensitivity <= 8'h7C;
    load_ref_pulse_width <= 10'h064;
  endtask
  task automatic waitStop();
    for (k = 0; k < 400 && stall_stop_event_flag !== 1'b1; k++) cyc(1);
  endtask
  task automatic reportAndStop();
    $display("compared %0d mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    errCount++;
    reportAndStop();
  end
  // ****
  // Scenarios
  // ****
  initial begin
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    cyc(1);
    chk("reset flag", 0, stall_stop_event_flag);
    chk("reset mode", 0, adaptiveActive);
    // Refusals, then one permitted case
    for (int c = 0; c < 6; c++) begin
      setGood();
      case (c)
        0: internalRamp <= 1'b0;
        1: adaptive_min_velocity <= 20'h0;
        2: silentChopperEnable <= 1'b1;
        3: highVelChopper <= 1'b0;
        4: rampTargetVelocity <= 20'h0FFFF;
        default: ;
      endcase
      cyc(4);
      chk("adaptive", c == 5, adaptiveActive);
      chk("fullstep", c == 5, fullStepMode);
      chk("constoff", c == 5, constOffChopper);
    end
    for (int t = 0; t < 16; t++) begin
      @(posedge core_clk) offTimeSetting <= t[3:0];
      cyc(2);
      chk("offtime", clampOff(t[3:0]), effOffTime);
    end
    fbCount = 0;
    // Random targets above the minimum, motor keeps up
    for (int i = 0; i < 20; i++) begin
      lfsr = nextRand(lfsr);
      v = {1'b1, lfsr[14:0], 4'hF};
      @(posedge core_clk) rampTargetVelocity <= v;
      @(posedge core_clk);
      cyc(1);
      chk("velocity", v, actual_velocity);
      cyc(20);
    end
    chk("running stall", 0, stallFlag);
    chk("feedback seen", 1, fbCount > 0);
    @(posedge core_clk) stop_on_stall_enable <= 1'b1;
    blocked <= 1'b1;
    waitStop();
    chk("stop flag", 1, stall_stop_event_flag);
    chk("stall", 1, stallFlag);
    chk("stopped", 0, actual_velocity);
    cyc(6);
    chk("still stopped", 0, actual_velocity);
    @(posedge core_clk) stall_stop_event_clear <= 1'b1;
    @(posedge core_clk) stall_stop_event_clear <= 1'b0;
    cyc(1);
    chk("cleared", 0, stall_stop_event_flag);
    waitStop();
    @(posedge core_clk) stop_on_stall_enable <= 1'b0;
    cyc(2);
    chk("disabled", 0, stall_stop_event_flag);
    cyc(4);
    chk("floor mode", 1, adaptiveActive);
    fbCount = 0;
    cyc(600);
    chk("floor steps", 1, fbCount > 0 && fbCount < 5);
    fbCount = 0;
    @(posedge core_clk) blocked <= 1'b0;
    cyc(600);
    chk("restart", rampTargetVelocity, actual_velocity);
    chk("restart steps", 1, fbCount > 4);
    chk("load range", 1, loadValue <= `LOAD_SLIP_MAX);
    reportAndStop();
  end
endmodule
